// file: hw/pflash_host.sv
// Host controller that issues command sequences to a byte-wide flash.
//
// Operation
// - Host keeps write strobe high during reads.
// - Host recovers device by writing FFH to 5555H.
// - Program is four write cycles ending in data.
// - Sector erase is six cycles ending 30H.
// - Chip erase ends with 10H to 5555H.
// - Autoselect entered by AAH, 55H, 90H.
// - Host does not erase before reprogramming used locations.
`timescale 1ns/10ps
module pflash_host #(
  parameter int ADDR_W = pflash_pkg::ADDR_W,
  parameter int DATA_W = pflash_pkg::DATA_W,
  parameter int PROGRAM_POLL_CYC = pflash_pkg::PROGRAM_POLL_CYC,
  parameter int SECTOR_POLL_CYC = pflash_pkg::SECTOR_POLL_CYC,
  parameter longint CHIP_POLL_CYC = pflash_pkg::CHIP_POLL_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // User request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [2:0] req_op_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_data_i,
  // User answer
  output logic rsp_valid_o,
  output logic [DATA_W-1:0] rsp_data_o,
  output logic rsp_timeout_o,
  output logic busy_o,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic chip_select_low_o,
  output logic output_gate_low_o,
  output logic write_strobe_low_o
);
  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_POLL = 3'b011,
    ST_PWAIT = 3'b100,
    ST_DONE = 3'b101
  } host_e;
  host_e st_q;
  logic [2:0] op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [2:0] step_q;
  logic [63:0] tmo_q;
  logic [DATA_W-1:0] rsp_q;
  logic rsp_v_q;
  logic tmo_flag_q;
  logic cyc_start;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  // ---------------------------------------------------------------
  // Step table for command sequences
  // ---------------------------------------------------------------
  wire is_erase = (op_q == pflash_pkg::OP_SECTOR_ERASE) || (op_q == pflash_pkg::OP_CHIP_ERASE);
  // Program is 4 cycles, erases 6, autoselect and long reset 3, abort 1.
  wire [2:0] last_step = (op_q == pflash_pkg::OP_READ) ? 3'h0 :
                         (op_q == pflash_pkg::OP_ABORT) ? 3'h0 :
                         (op_q == pflash_pkg::OP_PROGRAM) ? 3'h3 :
                         is_erase ? 3'h5 : 3'h2;
  wire unlock_b = (step_q == 3'h1) || (step_q == 3'h4);
  // The three-cycle reset ends in F0H to 5555H and returns the device to array read.
  wire [DATA_W-1:0] third_cmd = (op_q == pflash_pkg::OP_PROGRAM) ? pflash_pkg::CMD_PROGRAM :
                                (op_q == pflash_pkg::OP_AUTOSELECT) ? pflash_pkg::CMD_AUTOSELECT :
                                (op_q == pflash_pkg::OP_READ_RESET) ? pflash_pkg::CMD_READ_RESET :
                                pflash_pkg::CMD_ERASE_SETUP;
  // Sector erase targets an address inside the sector, chip erase uses 5555H.
  wire [DATA_W-1:0] last_cmd = (op_q == pflash_pkg::OP_CHIP_ERASE) ? pflash_pkg::CMD_CHIP_ERASE :
                               pflash_pkg::CMD_SECTOR_ERASE;
  wire [ADDR_W-1:0] last_addr = (op_q == pflash_pkg::OP_CHIP_ERASE) ? pflash_pkg::UNLOCK_ADDR1 : addr_q;
  wire [ADDR_W-1:0] step_addr = (op_q == pflash_pkg::OP_ABORT) ? pflash_pkg::UNLOCK_ADDR1 :
                                unlock_b ? pflash_pkg::UNLOCK_ADDR2 :
                                (op_q == pflash_pkg::OP_PROGRAM && step_q == 3'h3) ? addr_q :
                                (step_q == 3'h5) ? last_addr : pflash_pkg::UNLOCK_ADDR1;
  // Abort writes FFH to 5555H as a non-existent command.
  wire [DATA_W-1:0] step_data = (op_q == pflash_pkg::OP_ABORT) ? pflash_pkg::CMD_ABORT :
                                unlock_b ? pflash_pkg::UNLOCK_DATA2 :
                                (step_q == 3'h2) ? third_cmd :
                                (op_q == pflash_pkg::OP_PROGRAM && step_q == 3'h3) ? data_q :
                                (step_q == 3'h5) ? last_cmd : pflash_pkg::UNLOCK_DATA1;
  wire is_read = (op_q == pflash_pkg::OP_READ);
  wire needs_poll = (op_q == pflash_pkg::OP_PROGRAM) || is_erase;
  // Erase completes when the polled bit reads one; program when it equals the written bit.
  wire poll_target = is_erase ? 1'b1 : data_q[DATA_W-1];
  wire poll_ok = (cyc_rdata[DATA_W-1] == poll_target);
  wire [63:0] tmo_load = (op_q == pflash_pkg::OP_PROGRAM) ? 64'(PROGRAM_POLL_CYC) :
                         (op_q == pflash_pkg::OP_SECTOR_ERASE) ? 64'(SECTOR_POLL_CYC) : 64'(CHIP_POLL_CYC);

  assign cyc_start = (st_q == ST_ISSUE) || (st_q == ST_POLL);
  assign req_ready_o = (st_q == ST_IDLE);
  assign busy_o = (st_q != ST_IDLE);
  assign rsp_valid_o = rsp_v_q;
  assign rsp_data_o = rsp_q;
  assign rsp_timeout_o = tmo_flag_q;

  // ---------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= ST_IDLE;
      op_q <= pflash_pkg::OP_READ;
      addr_q <= '0;
      data_q <= '0;
      step_q <= 3'h0;
      tmo_q <= 64'h0;
      rsp_q <= '0;
      rsp_v_q <= 1'b0;
      tmo_flag_q <= 1'b0;
    end else begin
      rsp_v_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (req_valid_i) begin
            op_q <= req_op_i;
            addr_q <= req_addr_i;
            data_q <= req_data_i;
            step_q <= 3'h0;
            tmo_flag_q <= 1'b0;
            st_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (cyc_done) begin
            if (is_read) begin
              rsp_q <= cyc_rdata;
              st_q <= ST_DONE;
            end else if (step_q != last_step) begin
              step_q <= step_q + 3'h1;
              st_q <= ST_ISSUE;
            end else if (needs_poll) begin
              // Busy period starts after the final write; the next access is a poll read.
              op_q <= op_q;
              tmo_q <= tmo_load;
              st_q <= ST_POLL;
            end else begin
              st_q <= ST_DONE;
            end
          end
        end
        ST_POLL: st_q <= ST_PWAIT;
        ST_PWAIT: begin
          if (tmo_q != 64'h0) begin
            tmo_q <= tmo_q - 64'h1;
          end
          if (cyc_done) begin
            rsp_q <= cyc_rdata;
            if (poll_ok) begin
              st_q <= ST_DONE;
            end else if (tmo_q == 64'h0) begin
              // A program of a one into an already cleared bit 7 never polls true and ends here.
              tmo_flag_q <= 1'b1;
              st_q <= ST_DONE;
            end else begin
              st_q <= ST_POLL;
            end
          end
        end
        ST_DONE: begin
          rsp_v_q <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin engine
  // ---------------------------------------------------------------
  // Poll reads use the target address; chip select idles high for standby.
  wire cyc_write = (st_q == ST_ISSUE) && !is_read;
  wire [ADDR_W-1:0] cyc_addr = (st_q == ST_POLL || is_read) ? addr_q : step_addr;

  pflash_bus_cycle #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .READ_CYC(pflash_pkg::READ_CYC),
    .WE_LOW_CYC(pflash_pkg::WE_LOW_CYC),
    .WE_HIGH_CYC(pflash_pkg::WE_HIGH_CYC)
  ) u_cycle (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(cyc_start),
    .write_i(cyc_write),
    .addr_i(cyc_addr),
    .wdata_i(step_data),
    .done_o(cyc_done),
    .rdata_o(cyc_rdata),
    .addr_o(flash_addr_o),
    .dq_o(flash_dq_o),
    .dq_oe_o(flash_dq_oe_o),
    .dq_i(flash_dq_i),
    .chip_select_low_o(chip_select_low_o),
    .output_gate_low_o(output_gate_low_o),
    .write_strobe_low_o(write_strobe_low_o)
  );
endmodule : pflash_host

// file: hw/pflash_pkg.sv
// Shared constants for the parallel flash command controller.
package pflash_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECTOR_COUNT = 512;
  localparam int SECTOR_BYTES = 1024;
  localparam int BOOT_SECTORS = 32;
  localparam logic [18:0] BOOT_TOP_START = 19'h7c000;
  localparam logic [18:0] BOOT_TOP_END = 19'h7ffff;
  localparam logic [18:0] BOOT_BOT_START = 19'h00000;
  localparam logic [18:0] BOOT_BOT_END = 19'h3ffff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ---------------------------------------------------------------
  // Command addresses and codes
  // ---------------------------------------------------------------
  localparam logic [18:0] UNLOCK_ADDR1 = 19'h05555;
  localparam logic [18:0] UNLOCK_ADDR2 = 19'h02aaa;
  localparam logic [7:0] UNLOCK_DATA1 = 8'haa;
  localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
  localparam logic [7:0] CMD_READ_RESET = 8'hf0;
  localparam logic [7:0] CMD_ABORT = 8'hff;
  // ---------------------------------------------------------------
  // Operation codes on the user port
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_PROGRAM = 3'h1;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h2;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
  localparam logic [2:0] OP_AUTOSELECT = 3'h4;
  localparam logic [2:0] OP_READ_RESET = 3'h5;
  localparam logic [2:0] OP_ABORT = 3'h6;
  // ---------------------------------------------------------------
  // Bus timing at 25 MHz
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int READ_ACCESS_NS = 90;
  localparam int WE_PULSE_NS = 45;
  localparam int WE_HIGH_NS = 30;
  localparam int READ_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_LOW_CYC = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROGRAM_MAX_US = 20;
  localparam int SECTOR_ERASE_MAX_MS = 10;
  localparam int CHIP_ERASE_TYP_S = 2;
  localparam int PROGRAM_POLL_CYC = PROGRAM_MAX_US * 1000 / CLK_NS;
  localparam int SECTOR_POLL_CYC = SECTOR_ERASE_MAX_MS * 1000000 / CLK_NS;
  localparam longint CHIP_POLL_CYC = 64'(CHIP_ERASE_TYP_S) * 64'd1000000000 / 64'(CLK_NS);
endpackage : pflash_pkg

// file: hw/pflash_bus_cycle.sv
// Single bus cycle engine: one strobed read or one write-strobe pulse.
`timescale 1ns/10ps
module pflash_bus_cycle #(
  parameter int ADDR_W = 19,
  parameter int DATA_W = 8,
  parameter int READ_CYC = 3,
  parameter int WE_LOW_CYC = 2,
  parameter int WE_HIGH_CYC = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  output logic done_o,
  output logic [DATA_W-1:0] rdata_o,
  // Flash pins
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  input wire logic [DATA_W-1:0] dq_i,
  output logic chip_select_low_o,
  output logic output_gate_low_o,
  output logic write_strobe_low_o
);
  // ---------------------------------------------------------------
  // Cycle sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_READ = 2'b01,
    CY_WLOW = 2'b10,
    CY_WHIGH = 2'b11
  } cyc_e;
  cyc_e st_q;
  logic [3:0] cnt_q;
  wire cnt_end = (cnt_q == 4'h0);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= CY_IDLE;
      cnt_q <= 4'h0;
      addr_o <= '0;
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      rdata_o <= '0;
      done_o <= 1'b0;
      chip_select_low_o <= 1'b1;
      output_gate_low_o <= 1'b1;
      write_strobe_low_o <= 1'b1;
    end else begin
      done_o <= 1'b0;
      unique case (st_q)
        CY_IDLE: begin
          if (start_i && write_i) begin
            // Gate is parked high and chip select goes low with the strobe.
            st_q <= CY_WLOW;
            cnt_q <= 4'(WE_LOW_CYC - 1);
            addr_o <= addr_i;
            dq_o <= wdata_i;
            dq_oe_o <= 1'b1;
            chip_select_low_o <= 1'b0;
            write_strobe_low_o <= 1'b0;
          end else if (start_i) begin
            // Write strobe stays high for the whole read.
            st_q <= CY_READ;
            cnt_q <= 4'(READ_CYC);
            addr_o <= addr_i;
            chip_select_low_o <= 1'b0;
            output_gate_low_o <= 1'b0;
          end
        end
        CY_READ: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            // Data sampled while both strobes are low; then release both.
            rdata_o <= dq_i;
            chip_select_low_o <= 1'b1;
            output_gate_low_o <= 1'b1;
            st_q <= CY_IDLE;
            done_o <= 1'b1;
          end
        end
        CY_WLOW: begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_end) begin
            // Data is captured by the device on this rising edge.
            write_strobe_low_o <= 1'b1;
            chip_select_low_o <= 1'b1;
            cnt_q <= 4'(WE_HIGH_CYC - 1);
            st_q <= CY_WHIGH;
          end
        end
        CY_WHIGH: begin
          cnt_q <= cnt_q - 4'h1;
          dq_oe_o <= 1'b0;
          if (cnt_end) begin
            st_q <= CY_IDLE;
            done_o <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : pflash_bus_cycle

// file: tb/pflash_host_monitor.sv
// Concurrent checks on the flash host controller ports.
`timescale 1ns/10ps
module pflash_host_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // User side
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic [2:0] req_op_i,
  input wire logic rsp_valid_o,
  input wire logic busy_o,
  // Flash pins
  input wire logic [18:0] flash_addr_o,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic chip_select_low_o,
  input wire logic output_gate_low_o,
  input wire logic write_strobe_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  no_read_write_a: assert property (output_gate_low_o || write_strobe_low_o)
    else $error("gate and write strobe low together");
  gate_needs_select_a: assert property (!output_gate_low_o |-> !chip_select_low_o)
    else $error("gate low without chip select");
  no_drive_in_read_a: assert property (!output_gate_low_o |-> !flash_dq_oe_o)
    else $error("host drives data during read");
  read_window_a: assert property ($fell(output_gate_low_o) |-> !output_gate_low_o[*4] ##1 output_gate_low_o)
    else $error("read strobe length wrong");
  write_pulse_a: assert property ($fell(write_strobe_low_o) |->
    $fell(chip_select_low_o) ##1 !write_strobe_low_o ##1 write_strobe_low_o && chip_select_low_o)
    else $error("write pulse shape wrong");
  write_stable_a: assert property (!write_strobe_low_o && !$fell(write_strobe_low_o) |->
    $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved in write pulse");
  data_hold_a: assert property ($rose(write_strobe_low_o) |-> flash_dq_oe_o && $stable(flash_dq_o) ##1 !flash_dq_oe_o)
    else $error("data not held after write pulse");
  read_answer_a: assert property (req_valid_i && req_ready_o && req_op_i == pflash_pkg::OP_READ |-> ##[8:9] rsp_valid_o)
    else $error("read answer late");
  ready_idle_a: assert property (req_valid_i && req_ready_o |=> busy_o && !req_ready_o)
    else $error("request taken but controller not busy");
  answer_pulse_a: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("answer longer than one cycle");
endmodule : pflash_host_monitor

bind pflash_host pflash_host_monitor u_monitor (
  .clk_i(clk_i),
  .nrst_i(nrst_i),
  .req_valid_i(req_valid_i),
  .req_ready_o(req_ready_o),
  .req_op_i(req_op_i),
  .rsp_valid_o(rsp_valid_o),
  .busy_o(busy_o),
  .flash_addr_o(flash_addr_o),
  .flash_dq_o(flash_dq_o),
  .flash_dq_oe_o(flash_dq_oe_o),
  .chip_select_low_o(chip_select_low_o),
  .output_gate_low_o(output_gate_low_o),
  .write_strobe_low_o(write_strobe_low_o)
);

// file: tb/flash_model.sv
// Behavioural model of the byte-wide flash device behind the host.
`timescale 1ns/10ps
module flash_model #(
  parameter int BUSY_NS = 1000,
  parameter logic [7:0] ID_CODE = 8'h5e // Arbitrary value.
) (
  // Flash pins
  input wire logic [18:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  input wire logic chip_select_low_i,
  input wire logic output_gate_low_i,
  input wire logic write_strobe_low_i
);
  logic [7:0] mem [0:524287];
  logic [18:0] wa = 19'h00000;
  logic [7:0] rv = 8'h00;
  logic [7:0] pv = 8'h00;
  int step = 0;
  bit auto_q = 1'b0;
  bit erasing = 1'b0;
  bit tog = 1'b0;
  bit ers;
  realtime done_at = 0;
  wire wr = !chip_select_low_i && !write_strobe_low_i && output_gate_low_i;
  wire rd = !chip_select_low_i && !output_gate_low_i && write_strobe_low_i;
  // Undriven pins show the inverse of the last value rather than holding it.
  assign dq_o = rd ? rv : ~rv;
  initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
  // Address is taken as the strobes fall and data as they rise.
  always @(posedge wr) #1 wa = addr_i;
  always @(negedge wr) begin
    if ($realtime >= done_at) begin
      ers = step == 6 && (dq_i == 8'h30 || (dq_i == 8'h10 && wa == 19'h05555));
      auto_q = step == 2 && wa == 19'h05555 && dq_i == 8'h90;
      if (step == 6 && dq_i == 8'h30) for (int i = 0; i < 1024; i++) mem[{wa[18:10], i[9:0]}] = 8'hff;
      if (ers && dq_i == 8'h10) for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
      if (ers) begin
        erasing = 1'b1;
        done_at = $realtime + BUSY_NS;
      end
      if (step == 7) begin
        mem[wa] = mem[wa] & dq_i;
        pv = dq_i;
        erasing = 1'b0;
        done_at = $realtime + BUSY_NS;
      end
      case (step)
        0, 4: step = (wa == 19'h05555 && dq_i == 8'haa) ? step + 1 : 0;
        1, 5: step = (wa == 19'h02aaa && dq_i == 8'h55) ? step + 1 : 0;
        2: step = wa != 19'h05555 ? 0 : dq_i == 8'ha0 ? 7 : dq_i == 8'h80 ? 4 : 0;
        default: step = 0;
      endcase
      if (dq_i == 8'hf0) step = 0;
    end
  end
  always @(posedge rd) begin
    #1;
    tog = ~tog;
    if ($realtime < done_at) rv = {erasing ? 1'b0 : ~pv[7], tog, 6'h00};
    else if (auto_q) rv = addr_i[1:0] == 2'h0 ? ID_CODE : 8'h00;
    else rv = mem[addr_i];
  end
endmodule : flash_model

// file: tb/testbench.sv
// Self-checking bench for the flash host controller and its device model.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic [2:0] op; logic [18:0] addr; logic [7:0] data; logic chk; logic [7:0] exp;} row_s;
  localparam logic [7:0] ID = 8'h5e; // Arbitrary value.
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic [2:0] req_op_i = 3'h0;
  logic [18:0] req_addr_i = 19'h00000;
  logic [7:0] req_data_i = 8'h00;
  logic req_ready_o, rsp_valid_o, rsp_timeout_o, busy_o, flash_dq_oe_o;
  logic chip_select_low_o, output_gate_low_o, write_strobe_low_o;
  logic [7:0] rsp_data_o, flash_dq_o, model_dq, dq_bus;
  logic [18:0] flash_addr_o;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  row_s rows [23] = '{
    '{3'h0, 19'h00123, 8'h00, 1'b1, 8'hff},
    '{3'h1, 19'h00123, 8'h5a, 1'b1, 8'h5a},
    '{3'h0, 19'h00123, 8'h00, 1'b1, 8'h5a},
    '{3'h1, 19'h00523, 8'h3c, 1'b1, 8'h3c},
    '{3'h1, 19'h00523, 8'h0f, 1'b1, 8'h0c},
    '{3'h2, 19'h00100, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h00123, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h00523, 8'h00, 1'b1, 8'h0c},
    '{3'h4, 19'h00000, 8'h00, 1'b0, 8'h00},
    '{3'h0, 19'h00000, 8'h00, 1'b1, ID},
    '{3'h5, 19'h00000, 8'h00, 1'b0, 8'h00},
    '{3'h0, 19'h00000, 8'h00, 1'b1, 8'hff},
    '{3'h4, 19'h00000, 8'h00, 1'b0, 8'h00},
    '{3'h6, 19'h00000, 8'h00, 1'b0, 8'h00},
    '{3'h0, 19'h00000, 8'h00, 1'b1, 8'hff},
    '{3'h1, 19'h7c000, 8'ha5, 1'b1, 8'ha5},
    '{3'h1, 19'h7fc00, 8'h99, 1'b1, 8'h99},
    '{3'h2, 19'h7c3ff, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h7c000, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h7fc00, 8'h00, 1'b1, 8'h99},
    '{3'h3, 19'h05555, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h7c000, 8'h00, 1'b1, 8'hff},
    '{3'h0, 19'h00523, 8'h00, 1'b1, 8'hff}};
  assign dq_bus = flash_dq_oe_o ? flash_dq_o : model_dq;
  always #20 clk_i = ~clk_i;
  pflash_host #(.PROGRAM_POLL_CYC(2000), .SECTOR_POLL_CYC(2000), .CHIP_POLL_CYC(2000)) DUT (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_data_i(req_data_i), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .rsp_timeout_o(rsp_timeout_o), .busy_o(busy_o), .flash_addr_o(flash_addr_o),
    .flash_dq_o(flash_dq_o), .flash_dq_oe_o(flash_dq_oe_o), .flash_dq_i(dq_bus),
    .chip_select_low_o(chip_select_low_o), .output_gate_low_o(output_gate_low_o),
    .write_strobe_low_o(write_strobe_low_o));
  flash_model #(.BUSY_NS(1000), .ID_CODE(ID)) u_flash (
    .addr_i(flash_addr_o), .dq_i(dq_bus), .dq_o(model_dq), .chip_select_low_i(chip_select_low_o),
    .output_gate_low_i(output_gate_low_o), .write_strobe_low_i(write_strobe_low_o));
  task automatic summarize();
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Issues one request and waits a bounded time for its answer.
  task automatic run(input row_s r);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_op_i <= r.op;
    req_addr_i <= r.addr;
    req_data_i <= r.data;
    @(posedge clk_i);
    while (req_ready_o !== 1'b1) @(posedge clk_i);
    req_valid_i <= 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    check("answer", {7'h00, rsp_valid_o}, 8'h01);
  endtask : run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    foreach (rows[i]) begin
      run(rows[i]);
      if (rows[i].chk) check("data", rsp_data_o, rows[i].exp);
      check("timeout", {7'h00, rsp_timeout_o}, 8'h00);
    end
    // Reset in the middle of a program sequence.
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_op_i <= pflash_pkg::OP_PROGRAM;
    req_addr_i <= 19'h00040;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("strobes", {5'h00, chip_select_low_o, output_gate_low_o, write_strobe_low_o}, 8'h07);
    check("drive", {6'h00, flash_dq_oe_o, req_ready_o}, 8'h01);
    repeat (40) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    run(row_s'{3'h6, 19'h00000, 8'h00, 1'b0, 8'h00});
    run(row_s'{3'h0, 19'h00040, 8'h00, 1'b1, 8'hff});
    check("after abort", rsp_data_o, 8'hff);
    // A one cannot be programmed back over a zero, so polling must run out.
    run(row_s'{3'h1, 19'h00040, 8'h00, 1'b1, 8'h00});
    check("cleared byte", rsp_data_o, 8'h00);
    run(row_s'{3'h1, 19'h00040, 8'h80, 1'b1, 8'h80});
    check("poll timeout", {7'h00, rsp_timeout_o}, 8'h01);
    summarize();
  end
endmodule : testbench
